/* inc/gdc_consts.vh */
// Constants for the gate driver control register bank.
// Assumes a frame decoder outside hands over whole 16-bit words.
// Operation
// - Drive-option register at 0x02, resets to zero
// - Bit 9 set masks charge-pump undervoltage fault
// - Bit 8 set masks gate drive faults
// - Bit 7 routes temperature warning to fault
// - Bits 6-5 select six/three/single/independent input
// - Bit 4 picks freewheel rectification, single mode
// - Bit 3 ORed with phase C high direction, single mode
// - Bit 2 forces all gate outputs off
// - Bit 1 ORed with phase C low low_side_all_on, single mode
// - Bit 0 clears latched faults, self-clears
// - Key 110b locks all but key, 0x02[2:0]
// - Unlocked, other key values are ignored
// - Locked, 011b unlocks; key resets to 011b
// - High side resets 0x377, low 0x777
// - Peak drive time code 500 to 4000 ns
// - Retry-clear on PWM input for overcurrent
// - Overcurrent mode 01b means automatic retry
// - Summary fault is OR, mirrors fault pin
// - Frame: read flag, address, eleven data bits
`ifndef GDC_CONSTS_VH
`define GDC_CONSTS_VH
`define GDC_ADDR_DRV 4'h2
`define GDC_ADDR_HS 4'h3
`define GDC_ADDR_LS 4'h4
`define GDC_RST_DRV 11'h000
`define GDC_RST_HS 11'h377
`define GDC_RST_LS 11'h777
`define GDC_MASK_DRV 11'h3ff
`define GDC_MASK_HS 11'h777
`define GDC_MASK_LS 11'h777
`define GDC_LOCKED_KEEP 11'h007
`define GDC_KEY_LOCK 3'h6
`define GDC_KEY_UNLOCK 3'h3
`define GDC_OCP_RETRY 2'h1
`define GDC_MODE_SIX 2'h0
`define GDC_MODE_THREE 2'h1
`define GDC_MODE_SINGLE 2'h2
`define GDC_MODE_INDEP 2'h3
`define GDC_FRM_RD 15
`define GDC_FRM_ADDR_HI 14
`define GDC_FRM_ADDR_LO 11
`define GDC_FRM_DATA_HI 10
`define GDC_FRM_DATA_LO 0
`define GDC_KEY_HI 10
`define GDC_KEY_LO 8
`define GDC_LOW_HI 7
`define GDC_KEEP_HI 2
`define GDC_BIT_PUMP_OFF 9
`define GDC_BIT_GATE_OFF 8
`define GDC_BIT_WARN_REP 7
`define GDC_MODE_HI 6
`define GDC_MODE_LO 5
`define GDC_BIT_FREEWHEEL 4
`define GDC_BIT_DIR 3
`define GDC_BIT_HIZ 2
`define GDC_BIT_LOW_SIDE_ALL_ON 1
`define GDC_BIT_CLEAR 0
`define GDC_BIT_RETRY 10
`define GDC_SRC_LO 4
`define GDC_SNK_LO 0
`define GDC_TIME_HI 9
`define GDC_TIME_LO 8
`define GDC_SIDES 2
`define GDC_LOW_W 8
`define GDC_CODE_W 3
`define GDC_SRC_MA_W 8
`define GDC_SNK_MA_W 9
`define GDC_RST_KEY 3'h3
`define GDC_RST_HS_LOW 8'h77
`define GDC_MASK_CUR 8'h77
`define GDC_READ_NONE 11'h000
`define GDC_CODE_0 3'h0
`define GDC_CODE_1 3'h1
`define GDC_CODE_2 3'h2
`define GDC_CODE_3 3'h3
`define GDC_CODE_4 3'h4
`define GDC_CODE_5 3'h5
`define GDC_CODE_6 3'h6
`define GDC_SRC_MA_0 8'h0f
`define GDC_SRC_MA_1 8'h0f
`define GDC_SRC_MA_2 8'h2d
`define GDC_SRC_MA_3 8'h3c
`define GDC_SRC_MA_4 8'h5a
`define GDC_SRC_MA_5 8'h69
`define GDC_SRC_MA_6 8'h87
`define GDC_SRC_MA_7 8'h96
`define GDC_TIME_CODE_0 2'h0
`define GDC_TIME_CODE_1 2'h1
`define GDC_TIME_CODE_2 2'h2
`define GDC_TIME_NS_0 13'h01f4
`define GDC_TIME_NS_1 13'h03e8
`define GDC_TIME_NS_2 13'h07d0
`define GDC_TIME_NS_3 13'h0fa0
`endif

/* logic/gdc_regs.v */
// Gate driver control registers: drive options, high/low gate current.
// Assumes frame words arrive as one-cycle strobes synchronous to clock.
`include "gdc_consts.vh"
`default_nettype none
module gdc_regs (
  input wire clock,
  input wire sys_rst,
  input wire frame_valid,
  input wire [15:0] frame_word,
  output reg [10:0] read_data,
  output reg read_valid,
  input wire [1:0] overcurrent_handling,
  input wire drain_source_overcurrent,
  input wire sense_overcurrent,
  input wire pwm_edge,
  input wire temp_warning,
  input wire pump_uv_raw,
  input wire gate_fault_raw,
  input wire other_fault,
  input wire phase_c_high_in,
  input wire phase_c_low_in,
  output wire fault_out_n,
  output wire summary_fault,
  output wire latched_fault_clear,
  output wire overcurrent_auto_clear,
  output wire [1:0] input_mode,
  output wire single_mode,
  output wire single_input_freewheel,
  output wire single_input_direction,
  output wire low_side_all_on,
  output wire all_outputs_hiz,
  output wire [7:0] high_source_ma,
  output wire [8:0] high_sink_ma,
  output wire [7:0] low_source_ma,
  output wire [8:0] low_sink_ma,
  output wire [12:0] peak_drive_ns,
  output wire locked
);
  // ******************************
  // Decoders
  // ******************************
  // Source current in mA from a three-bit code
  function [7:0] src_ma;
    input [2:0] c;
    begin
      case (c)
        `GDC_CODE_0: src_ma = `GDC_SRC_MA_0;
        `GDC_CODE_1: src_ma = `GDC_SRC_MA_1;
        `GDC_CODE_2: src_ma = `GDC_SRC_MA_2;
        `GDC_CODE_3: src_ma = `GDC_SRC_MA_3;
        `GDC_CODE_4: src_ma = `GDC_SRC_MA_4;
        `GDC_CODE_5: src_ma = `GDC_SRC_MA_5;
        `GDC_CODE_6: src_ma = `GDC_SRC_MA_6;
        default: src_ma = `GDC_SRC_MA_7;
      endcase
    end
  endfunction

  // Sink steps are twice the source steps
  function [8:0] snk_ma;
    input [2:0] c;
    begin
      snk_ma = {src_ma(c), 1'b0};
    end
  endfunction

  // Peak drive time doubles per code step
  function [12:0] peak_ns;
    input [1:0] c;
    begin
      case (c)
        `GDC_TIME_CODE_0: peak_ns = `GDC_TIME_NS_0;
        `GDC_TIME_CODE_1: peak_ns = `GDC_TIME_NS_1;
        `GDC_TIME_CODE_2: peak_ns = `GDC_TIME_NS_2;
        default: peak_ns = `GDC_TIME_NS_3;
      endcase
    end
  endfunction

  // Address match, one per register
  function hit;
    input [3:0] a;
    input [3:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  // Reserved bits are cut on every write
  function [10:0] masked;
    input [10:0] d;
    input [10:0] m;
    begin
      masked = d & m;
    end
  endfunction

  // Key moves only on its one legal code for the present lock state
  function key_ok;
    input is_locked;
    input [2:0] k;
    begin
      if (is_locked) begin
        key_ok = (k == `GDC_KEY_UNLOCK);
      end else begin
        key_ok = (k == `GDC_KEY_LOCK);
      end
    end
  endfunction

  // Single-input mode out of the four input modes
  function is_single;
    input [1:0] m;
    begin
      case (m)
        `GDC_MODE_SIX: is_single = 1'b0;
        `GDC_MODE_THREE: is_single = 1'b0;
        `GDC_MODE_SINGLE: is_single = 1'b1;
        `GDC_MODE_INDEP: is_single = 1'b0;
        default: is_single = 1'b0;
      endcase
    end
  endfunction

  // Retry handling out of the overcurrent modes
  function is_retry;
    input [1:0] m;
    begin
      case (m)
        `GDC_OCP_RETRY: is_retry = 1'b1;
        default: is_retry = 1'b0;
      endcase
    end
  endfunction

  // ******************************
  // Frame fields
  // ******************************
  wire rd;
  wire [3:0] addr;
  wire [10:0] wd;
  wire wr;
  wire rd_take;

  assign rd = frame_word[`GDC_FRM_RD];
  assign addr = frame_word[`GDC_FRM_ADDR_HI:`GDC_FRM_ADDR_LO];
  assign wd = frame_word[`GDC_FRM_DATA_HI:`GDC_FRM_DATA_LO];
  assign wr = frame_valid & ~rd;
  assign rd_take = frame_valid & rd;

  // ******************************
  // Register selects
  // ******************************
  wire wr_drv;
  wire wr_hs;
  wire wr_ls;

  assign wr_drv = wr & hit(addr, `GDC_ADDR_DRV);
  assign wr_hs = wr & hit(addr, `GDC_ADDR_HS);
  assign wr_ls = wr & hit(addr, `GDC_ADDR_LS);

  // ******************************
  // Storage
  // ******************************
  reg [10:0] drv;
  reg [2:0] key;
  reg [7:0] hs_low;
  reg [10:0] ls;

  reg [10:0] next_drv;
  reg [2:0] next_key;
  reg [7:0] next_hs_low;
  reg [10:0] next_ls;
  reg [10:0] next_read_data;

  wire [10:0] hs;
  wire key_take;

  assign hs = {key, hs_low};
  assign locked = (key == `GDC_KEY_LOCK);
  assign key_take = key_ok(locked, wd[`GDC_KEY_HI:`GDC_KEY_LO]);

  // ******************************
  // Next values
  // ******************************
  // Clear bit falls back to zero one cycle after a write
  always @* begin
    next_drv = drv;
    next_drv[`GDC_BIT_CLEAR] = 1'b0;
    if (wr_drv) begin
      if (locked) begin
        // All_outputs_hiz, low_side_all_on and clear stay open so a locked host can still stop
        next_drv[`GDC_KEEP_HI:`GDC_BIT_CLEAR] = wd[`GDC_KEEP_HI:`GDC_BIT_CLEAR];
      end else begin
        next_drv = masked(wd, `GDC_MASK_DRV);
      end
    end
  end

  always @* begin
    next_key = key;
    if (wr_hs && key_take) begin
      next_key = wd[`GDC_KEY_HI:`GDC_KEY_LO];
    end
  end

  // Reserved current bits read back as zero
  always @* begin
    next_hs_low = hs_low;
    if (wr_hs && !locked) begin
      next_hs_low = wd[`GDC_LOW_HI:`GDC_FRM_DATA_LO] & `GDC_MASK_CUR;
    end
  end

  always @* begin
    next_ls = ls;
    if (wr_ls && !locked) begin
      next_ls = masked(wd, `GDC_MASK_LS);
    end
  end

  // Unmapped addresses read as zero
  always @* begin
    next_read_data = read_data;
    if (rd_take) begin
      case (addr)
        `GDC_ADDR_DRV: next_read_data = drv;
        `GDC_ADDR_HS: next_read_data = hs;
        `GDC_ADDR_LS: next_read_data = ls;
        default: next_read_data = `GDC_READ_NONE;
      endcase
    end
  end

  // ******************************
  // Registers
  // ******************************
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      drv <= `GDC_RST_DRV;
    end else begin
      drv <= next_drv;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      key <= `GDC_RST_KEY;
    end else begin
      key <= next_key;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hs_low <= `GDC_RST_HS_LOW;
    end else begin
      hs_low <= next_hs_low;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ls <= `GDC_RST_LS;
    end else begin
      ls <= next_ls;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      read_data <= `GDC_READ_NONE;
      read_valid <= 1'b0;
    end else begin
      read_data <= next_read_data;
      read_valid <= rd_take;
    end
  end

  // ******************************
  // Gate current decode
  // ******************************
  // Both sides share one field layout, so one loop decodes both
  wire [15:0] cur_low;
  wire [15:0] src_all;
  wire [17:0] snk_all;
  genvar side;

  assign cur_low = {ls[`GDC_LOW_HI:`GDC_FRM_DATA_LO], hs_low};
  generate
    for (side = 0; side < `GDC_SIDES; side = side + 1) begin : g_side
      assign src_all[side * `GDC_SRC_MA_W +: `GDC_SRC_MA_W] =
        src_ma(cur_low[side * `GDC_LOW_W + `GDC_SRC_LO +: `GDC_CODE_W]);
      assign snk_all[side * `GDC_SNK_MA_W +: `GDC_SNK_MA_W] =
        snk_ma(cur_low[side * `GDC_LOW_W + `GDC_SNK_LO +: `GDC_CODE_W]);
    end
  endgenerate

  assign high_source_ma = src_all[7:0];
  assign low_source_ma = src_all[15:8];
  assign high_sink_ma = snk_all[8:0];
  assign low_sink_ma = snk_all[17:9];

  // ******************************
  // Drive option outputs
  // ******************************
  assign input_mode = drv[`GDC_MODE_HI:`GDC_MODE_LO];
  assign single_mode = is_single(input_mode);
  assign single_input_freewheel = single_mode & drv[`GDC_BIT_FREEWHEEL];
  // Pin and bit are ORed only in single-input mode; other modes keep them low
  assign single_input_direction = single_mode & (drv[`GDC_BIT_DIR] | phase_c_high_in);
  assign all_outputs_hiz = drv[`GDC_BIT_HIZ];
  assign low_side_all_on = single_mode & (drv[`GDC_BIT_LOW_SIDE_ALL_ON] | phase_c_low_in);
  assign latched_fault_clear = drv[`GDC_BIT_CLEAR];

  // ******************************
  // Peak drive time
  // ******************************
  assign peak_drive_ns = peak_ns(ls[`GDC_TIME_HI:`GDC_TIME_LO]);

  // ******************************
  // Overcurrent retry
  // ******************************
  wire retry_mode;
  wire any_overcurrent;

  assign retry_mode = is_retry(overcurrent_handling);
  assign any_overcurrent = drain_source_overcurrent | sense_overcurrent;
  assign overcurrent_auto_clear = ls[`GDC_BIT_RETRY] & retry_mode
                                & pwm_edge & any_overcurrent;

  // ******************************
  // Fault summary
  // ******************************
  wire pump_uv_on;
  wire gate_fault_on;
  wire warn_on;

  assign pump_uv_on = pump_uv_raw & ~drv[`GDC_BIT_PUMP_OFF];
  assign gate_fault_on = gate_fault_raw & ~drv[`GDC_BIT_GATE_OFF];
  assign warn_on = temp_warning & drv[`GDC_BIT_WARN_REP];
  // Overcurrent and other faults have no mask bit in this bank
  assign summary_fault = pump_uv_on | gate_fault_on | warn_on
                       | any_overcurrent | other_fault;
  assign fault_out_n = ~summary_fault;
endmodule
`default_nettype wire

/* tb/gdc_chk_assertions.sv */
// Checker of gdc_regs frame, key, clear and fault timing.
// Assumes it is bound into every gdc_regs instance.
`default_nettype none
module gdc_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic frame_valid,
  input wire logic read_valid,
  input wire logic fault_out_n,
  input wire logic summary_fault,
  input wire logic latched_fault_clear,
  input wire logic overcurrent_auto_clear,
  input wire logic pwm_edge,
  input wire logic all_outputs_hiz,
  input wire logic locked,
  input wire logic [15:0] frame_word,
  input wire logic [1:0] overcurrent_handling
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_key(k); frame_valid && frame_word[15:8] == {5'h03, k}; endsequence
  sequence s_drv; frame_valid && frame_word[15:11] == 5'h02; endsequence
  chk_read_answer: assert property (frame_valid && frame_word[15] |=> read_valid)
    else $error("read not answered");
  chk_clear_pulse: assert property (s_drv ##0 frame_word[0] |=> latched_fault_clear
    ##1 ($past(frame_valid) || !latched_fault_clear)) else $error("clear not one pulse");
  chk_fault_pin: assert property (fault_out_n != summary_fault)
    else $error("fault pin not mirrored");
  chk_hiz_write: assert property (s_drv |=> all_outputs_hiz == $past(frame_word[2]))
    else $error("hiz bit not taken");
  chk_retry_clear: assert property (overcurrent_auto_clear |->
    pwm_edge && overcurrent_handling == 2'h1) else $error("clear outside retry");
  chk_lock_key: assert property (s_key(3'h6) |=> locked)
    else $error("lock key ignored");
  chk_unlock_key: assert property (locked ##0 s_key(3'h3) |=> !locked)
    else $error("unlock key ignored");
  chk_key_ignore: assert property (!locked && frame_valid && frame_word[15:11] == 5'h03
    && frame_word[10:8] != 3'h6 |=> !locked) else $error("wrong key locked");
endmodule
bind gdc_regs gdc_chk i_gdc_chk (.*);
`default_nettype wire

/* tb/gdc_host.sv */
// Host model: sends one 16-bit frame word per transfer.
// Assumes the bench calls xfer; read data lands one cycle on.
`default_nettype none
module gdc_host (
  input wire logic clock,
  input wire logic [10:0] read_data,
  output logic frame_valid,
  output logic [15:0] frame_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial frame_valid = 1'b0;
  initial frame_word = 16'h0000;
  task automatic xfer(input logic [15:0] w, output logic [10:0] q);
    @(posedge clock);
    frame_valid <= 1'b1;
    frame_word <= w;
    @(posedge clock);
    frame_valid <= 1'b0;
    frame_word <= ~w; // Idle word never repeats the last one
    #1 q = read_data;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of gdc_regs through the host model.
// Assumes a 20 MHz clock and active high reset.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, sys_rst = 1'b1;
  logic [10:0] f = 11'h000, q;
  logic frame_valid;
  logic [15:0] frame_word;
  wire [10:0] read_data;
  wire [7:0] ls_ma;
  wire [8:0] lk_ma;
  wire [12:0] pk_ns;
  wire fo_n, sf, dir, brk, oac, lk;
  int err_total = 0, compares = 0, cyc = 0;
  int src[8] = '{15, 15, 45, 60, 90, 105, 135, 150};
  gdc_regs i_gdc_regs (.clock, .sys_rst, .frame_valid, .frame_word, .read_data, .read_valid(),
    .overcurrent_handling(f[10:9]), .drain_source_overcurrent(f[8]), .sense_overcurrent(f[7]),
    .pwm_edge(f[6]), .temp_warning(f[5]), .pump_uv_raw(f[4]), .gate_fault_raw(f[3]),
    .other_fault(f[2]), .phase_c_high_in(f[1]), .phase_c_low_in(f[0]), .fault_out_n(fo_n),
    .summary_fault(sf), .latched_fault_clear(), .overcurrent_auto_clear(oac), .input_mode(),
    .single_mode(), .single_input_freewheel(), .single_input_direction(dir),
    .low_side_all_on(brk), .all_outputs_hiz(), .high_source_ma(), .high_sink_ma(),
    .low_source_ma(ls_ma), .low_sink_ma(lk_ma), .peak_drive_ns(pk_ns), .locked(lk));
  gdc_host i_gdc_host (.clock, .read_data, .frame_valid, .frame_word);
  task automatic cmp(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    i_gdc_host.xfer({1'b0, a, d}, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [10:0] e);
    i_gdc_host.xfer({1'b1, a, 11'h000}, q);
    cmp(16'(q), 16'(e));
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #25 clock = ~clock;
  // Generous ceiling; the tests need about 60 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rd(4'h2, 11'h000);
    rd(4'h3, 11'h377);
    rd(4'h4, 11'h777);
    rd(4'h5, 11'h000);
    cmp(16'(pk_ns), 16'h0fa0);
    for (int i = 0; i < 8; i++) begin
      wr(4'h4, {1'b0, 2'(i), 1'b0, 3'(i), 1'b0, 3'(i)});
      cmp(16'(ls_ma), 16'(src[i]));
      cmp(16'(lk_ma), 16'(2 * src[i]));
      cmp(16'(pk_ns), 16'(500 << (i % 4)));
    end
    $display("test reset and decode done");
    @(posedge clock) f <= 11'h022;
    wr(4'h2, 11'h043);
    rd(4'h2, 11'h042);
    cmp({13'h0000, dir, brk, sf}, 16'h0006);
    wr(4'h2, 11'h0c0);
    cmp({14'h0000, fo_n, sf}, 16'h0001);
    @(posedge clock) f <= 11'h018;
    #1 cmp(16'(sf), 16'h0001);
    wr(4'h2, 11'h300);
    cmp(16'(sf), 16'h0000);
    $display("test drive options done");
    wr(4'h3, 11'h611);
    wr(4'h4, 11'h000);
    rd(4'h4, 11'h377);
    wr(4'h3, 11'h500);
    cmp(16'(lk), 16'h0001);
    wr(4'h3, 11'h300);
    rd(4'h3, 11'h311);
    wr(4'h3, 11'h577);
    rd(4'h3, 11'h377);
    wr(4'h4, 11'h400);
    @(posedge clock) f <= 11'h340;
    #1 cmp(16'(oac), 16'h0001);
    @(posedge clock) f <= 11'h140;
    #1 cmp(16'(oac), 16'h0000);
    $display("test lock and retry done");
    stop_test;
  end
endmodule
`default_nettype wire
